// ### inc/uec_pkg.sv
/*
 * Package for the control endpoint handler: register offsets, field
 * positions, reset values, limits and carrier structs.
 * Assumes a 32-bit APB slave with one aligned word per register.
 */
package uec_pkg;

   // ***************************************************
   // Register byte offsets
   // ***************************************************
   localparam logic [7:0] OFF_IN_EP_INT = 8'h08;
   localparam logic [7:0] OFF_CTRL_EP_CS = 8'h10;
   localparam logic [7:0] OFF_CTRL_EP_CNT = 8'h14;
   localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

   // ***************************************************
   // Control/status field positions
   // ***************************************************
   localparam int CS_OUT_PKT_RDY = 0;
   localparam int CS_IN_PKT_RDY = 1;
   localparam int CS_SENT_STALL = 2;
   localparam int CS_DATA_END = 3;
   localparam int CS_SETUP_END = 4;
   localparam int CS_SEND_STALL = 5;
   localparam int CS_SVC_OUT_PKT = 6;
   localparam int CS_SVC_SETUP_END = 7;

   // Interrupt event bit positions
   localparam int EV_EP0 = 0;
   localparam int EV_STALL = 1;
   localparam int EV_SETUP_END = 2;
   localparam int EV_NUM = 3;

   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] SETUP_LEN = 8'h08;
   localparam logic [7:0] MAX_PKT = 8'h40;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

   // Token kinds from the serial interface engine
   typedef enum logic [1:0] {
      UEC_TOK_NONE,
      UEC_TOK_SETUP,
      UEC_TOK_OUT,
      UEC_TOK_IN
   } uec_tok_t;

   // Received packet report
   typedef struct packed {
      logic valid;
      uec_tok_t tok;
      logic data1;
      logic [7:0] len;
   } uec_rx_t;

   // Handshake request to the engine
   typedef struct packed {
      logic nak;
      logic stall;
      logic send;
   } uec_hs_t;

endpackage

// ### design/uec_ctrl_ep.sv
/*
 * Endpoint 0 control-transfer handler of a full-speed function controller.
 * Assumes the serial engine reports each token with its data length once
 * per transaction, and reports in_done when a loaded IN packet went out.
 * Holds the control/status bits, the received byte count, the read-to-clear
 * IN endpoint flags and a status/mask interrupt pair, all behind APB.
 * Assumes rx is a one-cycle pulse per token, with len valid alongside it,
 * and that in_short is only meaningful while in_done is high.
 * Assumes APB runs in the pclk domain; every access completes with no
 * wait state, so read data is combinational from the address.
 * The FIFO itself lives outside; fifo_pop only tells the count that
 * firmware has taken one byte.
 */
//
// Contract
// - Reading the IN endpoint interrupt register clears its pending flags.
// - Flags at bits 0..2 (ep0, ep1, ep2); bits 7..3 read zero.
// - Setup-end set when a transfer ends before data-end was set; the code sets it only on a SETUP/OUT token in Transmit Mode.
// - Byte count register reports received bytes held in the endpoint FIFO.
// - Protocol errors answered with STALL; firmware may force STALL.
// - Every STALL sets sent-stall and raises an endpoint 0 interrupt.
// - Stall extra OUT or IN token in data phase after data-end.
// - Stall oversize packet and non-zero DATA1 in IN status phase.
// - Writing one to send-stall bit 5 makes endpoint 0 stall.
// - SETUP packets not exactly 8 bytes are rejected.
// - Endpoint 0 interrupt once SETUP data lands in the FIFO.
// - Interrupt after IN packet sent; none for IN before loading.
// - IN token answered NAK while in-packet-ready is zero.
// - First IN token enters Transmit Mode; SETUP/OUT there sets setup-end.
// - Transmit Mode ends on SETUP/OUT token, short or empty packet.
`timescale 1ns/1ps
module uec_ctrl_ep (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire uec_pkg::uec_rx_t rx,
   input wire logic in_done,
   input wire logic in_short,
   input wire logic in_ep1_event,
   input wire logic in_ep2_event,
   input wire logic fifo_pop,
   output uec_pkg::uec_hs_t hs,
   output logic irq
);

   // ***************************************************
   // State
   // ***************************************************
   typedef enum logic [1:0] {
      UEC_IDLE,
      UEC_RX_DATA,
      UEC_TX_MODE,
      UEC_STATUS
   } uec_state_t;

   uec_state_t state_q;
   logic [2:0] in_flags_q;
   logic out_rdy_q;
   logic in_rdy_q;
   logic stall_sent_q;
   logic data_end_q;
   logic setup_end_q;
   logic send_stall_q;
   logic [7:0] count_q;
   logic [uec_pkg::EV_NUM-1:0] ev_status_q;
   logic [uec_pkg::EV_NUM-1:0] ev_mask_q;
   logic [uec_pkg::EV_NUM-1:0] ev_set;
   uec_pkg::uec_hs_t hs_q;

   logic wr;
   logic rd;
   logic tok_setup;
   logic tok_out;
   logic tok_in;
   logic setup_ok;
   logic proto_err;
   logic stall_now;
   logic ep0_event;
   logic wr_cs;
   logic wr_cs_in_rdy;
   logic wr_cs_data_end;
   logic wr_cs_stall;
   logic in_sent;
   logic tx_exit;
   logic setup_end_set;
   logic flag_rd_clr;
   logic [2:0] in_flag_set;

   // ***************************************************
   // Bus decode
   // ***************************************************
   assign wr = psel && penable && pwrite;
   assign rd = psel && penable && !pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;

   // ***************************************************
   // Token decode
   // ***************************************************
   assign tok_setup = rx.valid && rx.tok == uec_pkg::UEC_TOK_SETUP;
   assign tok_out = rx.valid && rx.tok == uec_pkg::UEC_TOK_OUT;
   assign tok_in = rx.valid && rx.tok == uec_pkg::UEC_TOK_IN;
   assign setup_ok = tok_setup && rx.len == uec_pkg::SETUP_LEN;

   // ***************************************************
   // Protocol error detection
   // ***************************************************
   always_comb begin
      proto_err = 1'b0;
      if (tok_out && data_end_q && state_q == UEC_RX_DATA) begin
         proto_err = 1'b1;
      end
      // Data phase is over once the last packet has left with data-end set
      if (tok_in && data_end_q && !in_rdy_q && (state_q == UEC_TX_MODE || state_q == UEC_STATUS)) begin
         proto_err = 1'b1;
      end
      if ((tok_out || tok_setup) && rx.len > uec_pkg::MAX_PKT) begin
         proto_err = 1'b1;
      end
      if (tok_out && state_q == UEC_STATUS && rx.data1 && rx.len != 8'h00) begin
         proto_err = 1'b1;
      end
   end

   assign stall_now = rx.valid && (proto_err || send_stall_q);
   assign in_sent = in_done && in_rdy_q;
   assign tx_exit = in_sent && in_short;
   // A SETUP or OUT token inside Transmit Mode before data-end is set cuts the transfer short
   assign setup_end_set = (tok_setup || tok_out) && state_q == UEC_TX_MODE && !data_end_q;

   // ***************************************************
   // Register write strobes
   // ***************************************************
   assign wr_cs = wr && paddr == uec_pkg::OFF_CTRL_EP_CS;
   assign wr_cs_in_rdy = wr_cs && pwdata[uec_pkg::CS_IN_PKT_RDY];
   assign wr_cs_data_end = wr_cs && pwdata[uec_pkg::CS_DATA_END];
   assign wr_cs_stall = wr_cs && pwdata[uec_pkg::CS_SEND_STALL];

   // ***************************************************
   // Transfer state
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= UEC_IDLE;
      end else if (stall_now || tok_setup) begin
         state_q <= (setup_ok && !stall_now) ? UEC_RX_DATA : UEC_IDLE;
      end else if (tok_in && state_q != UEC_TX_MODE && state_q != UEC_STATUS) begin
         state_q <= UEC_TX_MODE;
      end else if (tok_out && state_q == UEC_TX_MODE) begin
         state_q <= UEC_IDLE;
      end else if (tx_exit) begin
         state_q <= UEC_STATUS;
      end
   end

   // ***************************************************
   // Control/status bits
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_rdy_q <= 1'b0;
      end else if (setup_ok && !stall_now) begin
         out_rdy_q <= 1'b1;
      end else if (wr_cs && pwdata[uec_pkg::CS_SVC_OUT_PKT]) begin
         out_rdy_q <= 1'b0;
      end
   end

   // Firmware sets it; a sent packet or a stall drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         in_rdy_q <= 1'b0;
      end else if (wr_cs_in_rdy) begin
         in_rdy_q <= 1'b1;
      end else if (in_sent || stall_now) begin
         in_rdy_q <= 1'b0;
      end
   end

   // Cleared when a new transfer starts or the endpoint stalls
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_end_q <= 1'b0;
      end else if (wr_cs_data_end) begin
         data_end_q <= 1'b1;
      end else if (tok_setup || stall_now) begin
         data_end_q <= 1'b0;
      end
   end

   // Level bit: every token is stalled while it stays set
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         send_stall_q <= 1'b0;
      end else if (wr_cs) begin
         send_stall_q <= pwdata[uec_pkg::CS_SEND_STALL];
      end
   end

   // Hardware set wins over a firmware clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stall_sent_q <= 1'b0;
      end else if (stall_now) begin
         stall_sent_q <= 1'b1;
      end else if (wr_cs && !pwdata[uec_pkg::CS_SENT_STALL]) begin
         stall_sent_q <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setup_end_q <= 1'b0;
      end else if (setup_end_set) begin
         setup_end_q <= 1'b1;
      end else if (wr_cs && pwdata[uec_pkg::CS_SVC_SETUP_END]) begin
         setup_end_q <= 1'b0;
      end
   end

   // ***************************************************
   // Received byte count
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_q <= uec_pkg::RST_BYTE;
      end else if ((setup_ok || tok_out) && !stall_now) begin
         count_q <= rx.len;
      end else if (fifo_pop && count_q != 8'h00) begin
         count_q <= count_q - 8'h01;
      end
   end

   // ***************************************************
   // Handshake answer
   // ***************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hs_q <= '0;
      end else begin
         hs_q.stall <= stall_now;
         hs_q.nak <= tok_in && !stall_now && !in_rdy_q;
         hs_q.send <= tok_in && !stall_now && in_rdy_q;
      end
   end
   assign hs = hs_q;

   // ***************************************************
   // IN endpoint flags, cleared by a read
   // ***************************************************
   assign ep0_event = (setup_ok && !stall_now) || in_sent || stall_now;
   assign flag_rd_clr = rd && paddr == uec_pkg::OFF_IN_EP_INT;
   assign in_flag_set = {in_ep2_event, in_ep1_event, ep0_event};

   // An event in the clearing read cycle survives, so none is lost
   genvar fi;
   generate
      for (fi = 0; fi < 3; fi++) begin : g_flag
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               in_flags_q[fi] <= 1'b0;
            end else if (in_flag_set[fi]) begin
               in_flags_q[fi] <= 1'b1;
            end else if (flag_rd_clr) begin
               in_flags_q[fi] <= 1'b0;
            end
         end
      end
   endgenerate

   // ***************************************************
   // Interrupt status and mask
   // ***************************************************
   // Setup-end event only on the first setting of the status bit
   assign ev_set = {setup_end_set && !setup_end_q, stall_now, ep0_event};

   genvar gi;
   generate
      for (gi = 0; gi < uec_pkg::EV_NUM; gi++) begin : g_ev
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               ev_status_q[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
               ev_status_q[gi] <= 1'b1;
            end else if (wr && paddr == uec_pkg::OFF_IRQ_STATUS && pwdata[gi]) begin
               ev_status_q[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_mask_q <= '0;
      end else if (wr && paddr == uec_pkg::OFF_IRQ_MASK) begin
         ev_mask_q <= pwdata[uec_pkg::EV_NUM-1:0];
      end
   end

   // ***************************************************
   // Interrupt output
   // ***************************************************
   assign irq = |(ev_status_q & ev_mask_q);

   // ***************************************************
   // Read data
   // ***************************************************
   always_comb begin
      unique case (paddr)
         uec_pkg::OFF_IN_EP_INT: prdata = {29'h0, in_flags_q};
         uec_pkg::OFF_CTRL_EP_CS: prdata = {26'h0, send_stall_q, setup_end_q,
                                            data_end_q, stall_sent_q,
                                            in_rdy_q, out_rdy_q};
         uec_pkg::OFF_CTRL_EP_CNT: prdata = {24'h0, count_q};
         uec_pkg::OFF_IRQ_STATUS: prdata = {29'h0, ev_status_q};
         uec_pkg::OFF_IRQ_MASK: prdata = {29'h0, ev_mask_q};
         default: prdata = uec_pkg::UNMAPPED_DATA;
      endcase
   end

endmodule

// ### verification/uec_props.sv
/* Port assertions for the control endpoint handler.
   Assumes it is bound to uec_ctrl_ep, single clock pclk. */
`timescale 1ns/1ps
module uec_props (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire uec_pkg::uec_rx_t rx,
   input wire logic in_ep1_event,
   input wire logic in_ep2_event,
   input wire uec_pkg::uec_hs_t hs
);
   // *****
   // Flag reads and handshakes
   // *****
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire flag_rd = psel && !pwrite && paddr == uec_pkg::OFF_IN_EP_INT;
   wire ev = in_ep1_event || in_ep2_event;
   sequence clr_read;
      flag_rd && penable && !ev;
   endsequence
   sequence next_read;
      !(flag_rd && penable) ##1 flag_rd;
   endsequence
   reserved_bits_a:
      assert property (flag_rd |-> prdata[31:3] == 29'h0) else $error("flag reserved bits set");
   read_clear_a:
      assert property (clr_read ##1 !ev ##1 flag_rd |-> prdata[2:1] == 2'b00) else $error("flags kept after read");
   ep1_flag_a:
      assert property (in_ep1_event && !(flag_rd && penable) ##1 next_read |-> prdata[1]) else $error("ep1 flag lost");
   ep2_flag_a:
      assert property (in_ep2_event && !(flag_rd && penable) ##1 next_read |-> prdata[2]) else $error("ep2 flag lost");
   hs_cause_a:
      assert property (hs != 3'b000 |-> $onehot(hs) && $past(rx.valid)) else $error("handshake without token");
   in_answer_a:
      assert property (rx.valid && rx.tok == uec_pkg::UEC_TOK_IN |=> hs != 3'b000) else $error("IN token unanswered");
   oversize_a:
      assert property (rx.valid && rx.len > uec_pkg::MAX_PKT |=> hs.stall) else $error("oversize not stalled");
   setup_len_a:
      assert property (rx.valid && rx.tok == uec_pkg::UEC_TOK_SETUP && rx.len != uec_pkg::SETUP_LEN |=> !hs.send)
      else $error("bad setup accepted");
endmodule

// ### verification/uec_host_model.sv
/* Host side of the serial engine: tokens on request, IN completion.
   Assumes the bench calls token and sets pkt_len and pkt_gap. */
`timescale 1ns/1ps
module uec_host_model (
   input wire logic pclk,
   input wire uec_pkg::uec_hs_t hs,
   output uec_pkg::uec_rx_t rx,
   output logic in_done,
   output logic in_short
);
   // *****
   // Token and completion driver
   // *****
   int pkt_gap = 0;
   logic [7:0] pkt_len = 8'h00;
   initial begin
      rx = '0;
      in_done = 1'b0;
      in_short = 1'b0;
   end
   task automatic token(input uec_pkg::uec_tok_t t, input logic [7:0] n);
      @(posedge pclk);
      rx <= '{1'b1, t, 1'b0, n};
      @(posedge pclk);
      rx <= '{1'b0, uec_pkg::uec_tok_t'(~t), 1'b1, ~n};
   endtask
   // Short flag is garbage outside a completion
   always @(posedge pclk) begin
      if (hs.send) begin
         repeat (pkt_gap) @(posedge pclk);
         in_done <= 1'b1;
         in_short <= pkt_len < uec_pkg::MAX_PKT;
         @(posedge pclk);
         in_done <= 1'b0;
      end else begin
         in_short <= ~in_short;
      end
   end
endmodule

// ### verification/testbench.sv
/* Self-checking bench: firmware over APB, host model on the engine side.
   Assumes uec_props and uec_host_model are compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
   // *****
   // Design, host and firmware tasks
   // *****
   logic pclk, presetn, psel, penable, pwrite, in_ep1_event, in_ep2_event, fifo_pop;
   logic pready, pslverr, irq, in_done, in_short;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [31:0] seed = 32'h9FAACFF7;
   uec_pkg::uec_rx_t rx;
   uec_pkg::uec_hs_t hs;
   int err_count = 0;
   int samples_checked = 0;
   int k;
   uec_ctrl_ep uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx(rx),
      .in_done(in_done), .in_short(in_short), .in_ep1_event(in_ep1_event), .in_ep2_event(in_ep2_event),
      .fifo_pop(fifo_pop), .hs(hs), .irq(irq));
   uec_host_model host (.pclk(pclk), .hs(hs), .rx(rx), .in_done(in_done), .in_short(in_short));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] flags(input logic e0, input logic e1, input logic e2);
      return {29'h0, e2, e1, e0};
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      if (n >= 20) begin
         err_count++;
         stop_test();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK($sformatf("reg %0h", a), e, r & m)
      `CHK("pslverr", 1'b0, pslverr)
   endtask
   task automatic tok(input uec_pkg::uec_tok_t t, input logic [7:0] n, input logic [2:0] m, input logic [2:0] e);
      host.token(t, n);
      #1;
      if (m != 3'b000) `CHK("handshake", e, hs & m)
   endtask
   task automatic irq_is(input logic e);
      #1;
      `CHK("irq", e, irq)
   endtask
   task automatic pulse(input logic [2:0] v, input int c);
      @(posedge pclk);
      {in_ep2_event, in_ep1_event, fifo_pop} <= v;
      repeat (c) @(posedge pclk);
      {in_ep2_event, in_ep1_event, fifo_pop} <= 3'b000;
   endtask
   task automatic done_wait();
      int n;
      n = 0;
      while (in_done !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n >= 20) begin
         err_count++;
         stop_test();
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      stop_test();
   end
   initial begin
      {presetn, psel, penable, pwrite, in_ep1_event, in_ep2_event, fifo_pop} = 7'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (k = 8; k <= 8'h40; k += 4) rd(k[7:0], 32'hFFFFFFFF, 32'h0);
      apb(1'b1, 8'h40, 32'hFFFFFFFF);
      rd(8'h40, 32'hFFFFFFFF, 32'h0);
      $display("test reset done");
      pulse(3'b110, 1);
      rd(uec_pkg::OFF_IN_EP_INT, 32'hFFFFFFFF, flags(1'b0, 1'b1, 1'b1));
      rd(uec_pkg::OFF_IN_EP_INT, 32'hFFFFFFFF, flags(1'b0, 1'b0, 1'b0));
      apb(1'b1, uec_pkg::OFF_IN_EP_INT, 32'hFF);
      rd(uec_pkg::OFF_IN_EP_INT, 32'hFFFFFFFF, 32'h0);
      $display("test flags done");
      for (k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         tok(uec_pkg::UEC_TOK_SETUP, {5'h0, seed[2:0]}, 3'b001, 3'b000);
      end
      rd(uec_pkg::OFF_CTRL_EP_CS, 32'hFF, 32'h0);
      rd(uec_pkg::OFF_CTRL_EP_CNT, 32'hFF, 32'h0);
      tok(uec_pkg::UEC_TOK_SETUP, uec_pkg::SETUP_LEN, 3'b000, 3'b000);
      rd(uec_pkg::OFF_CTRL_EP_CNT, 32'hFF, 32'h8);
      rd(uec_pkg::OFF_IN_EP_INT, 32'h1, 32'h1);
      seed = lfsr(seed);
      pulse(3'b001, 1 + seed[1:0]);
      rd(uec_pkg::OFF_CTRL_EP_CNT, 32'hFF, 32'h7 - seed[1:0]);
      apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h40);
      rd(uec_pkg::OFF_CTRL_EP_CS, 32'h1, 32'h0);
      tok(uec_pkg::UEC_TOK_IN, 8'h00, 3'b111, 3'b100);
      rd(uec_pkg::OFF_IN_EP_INT, 32'h1, 32'h0);
      $display("test setup done");
      apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h02);
      host.pkt_len = uec_pkg::MAX_PKT;
      host.pkt_gap = seed[3:2];
      tok(uec_pkg::UEC_TOK_IN, 8'h00, 3'b111, 3'b001);
      done_wait();
      rd(uec_pkg::OFF_CTRL_EP_CS, 32'h02, 32'h0);
      rd(uec_pkg::OFF_IN_EP_INT, 32'h1, 32'h1);
      tok(uec_pkg::UEC_TOK_OUT, 8'h00, 3'b000, 3'b000);
      rd(uec_pkg::OFF_CTRL_EP_CS, 32'h10, 32'h10);
      apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h80);
      rd(uec_pkg::OFF_CTRL_EP_CS, 32'h10, 32'h0);
      for (k = 0; k < 2; k++) begin
         tok(uec_pkg::UEC_TOK_SETUP, uec_pkg::SETUP_LEN, 3'b000, 3'b000);
         apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h4A);
         host.pkt_len = k ? 8'h0A : 8'h00;
         tok(uec_pkg::UEC_TOK_IN, 8'h00, 3'b111, 3'b001);
         done_wait();
         apb(1'b0, uec_pkg::OFF_IN_EP_INT, 32'h0);
         if (k == 0) begin
            tok(uec_pkg::UEC_TOK_OUT, 8'h00, 3'b000, 3'b000);
            rd(uec_pkg::OFF_CTRL_EP_CS, 32'h10, 32'h0);
         end else begin
            tok(uec_pkg::UEC_TOK_IN, 8'h00, 3'b111, 3'b010);
            rd(uec_pkg::OFF_CTRL_EP_CS, 32'h04, 32'h04);
            rd(uec_pkg::OFF_IN_EP_INT, 32'h1, 32'h1);
         end
      end
      $display("test transmit done");
      apb(1'b1, uec_pkg::OFF_IRQ_MASK, 32'h02);
      irq_is(1'b1);
      apb(1'b1, uec_pkg::OFF_IRQ_STATUS, 32'h02);
      irq_is(1'b0);
      apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h20);
      tok(uec_pkg::UEC_TOK_OUT, 8'h00, 3'b111, 3'b010);
      rd(uec_pkg::OFF_IRQ_STATUS, 32'h02, 32'h02);
      irq_is(1'b1);
      apb(1'b1, uec_pkg::OFF_CTRL_EP_CS, 32'h00);
      apb(1'b1, uec_pkg::OFF_IRQ_MASK, 32'h00);
      irq_is(1'b0);
      tok(uec_pkg::UEC_TOK_OUT, uec_pkg::MAX_PKT + 8'h01, 3'b111, 3'b010);
      $display("test stall done");
      stop_test();
   end
endmodule
bind uec_ctrl_ep uec_props chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .rx(rx), .in_ep1_event(in_ep1_event), .in_ep2_event(in_ep2_event), .hs(hs));
